// [include/rlg_consts.svh]
// offsets, field positions, reset values and scale factors of the reference and gain block
// assumes inclusion by bare name from the design file and the testbench
`ifndef RLG_CONSTS_SVH
`define RLG_CONSTS_SVH

// register offsets
`define RLG_OFS_ENABLE 8'h00
`define RLG_OFS_REF_CODE 8'h01
`define RLG_OFS_CONFIG 8'h03
`define RLG_OFS_GAIN 8'h08

// field positions
`define RLG_EN_BIT 0
`define RLG_HALF_BIT 4
`define RLG_FREQ_MSB 2
`define RLG_GAIN_MSB 2

// reset values
`define RLG_EN_RST 1'b1
`define RLG_REF_CODE_RST 8'h32
`define RLG_HALF_RST 1'b0
`define RLG_FREQ_RST 3'h0
`define RLG_GAIN_RST 3'h5

// reference scaling in millivolts
`define RLG_STEP_MV 12'h00a
`define RLG_HALF_MV 12'h005
`define RLG_REF_RST_MV 12'h1f4
`define RLG_CODE_MIN 8'h0a

// amplifier transconductance table, microsiemens
`define RLG_GM_0 10'h057
`define RLG_GM_1 10'h064
`define RLG_GM_2 10'h075
`define RLG_GM_3 10'h14d
`define RLG_GM_4 10'h190
`define RLG_GM_5 10'h1f4
`define RLG_GM_6 10'h29b
`define RLG_GM_7 10'h3e8

`endif

// [include/rlg_pkg.sv]
// types shared by the reference and gain configuration block
// assumes rlg_consts.svh is on the include path
`default_nettype none
package rlg_pkg;

    // switch pattern mode
    typedef enum logic [1:0] {
        RLG_MODE_OFF = 2'b00,
        RLG_MODE_BUCK = 2'b01,
        RLG_MODE_BOOST = 2'b10
    } rlg_mode_e;

    // whole state of the block
    typedef struct packed {
        logic en_reg;
        logic [7:0] ref_code;
        logic half_step;
        logic [2:0] freq_sel;
        logic [2:0] gain_sel;
        logic [7:0] rdata;
        logic rvalid;
        logic [11:0] ref_mv;
        logic [9:0] gm_us;
        logic code_reserved;
        logic conv_en;
        rlg_mode_e mode;
        logic [3:0] sw;
    } rlg_state_s;

endpackage

`default_nettype wire

// [rtl/rlg_core.sv]
// reference code, amplifier gain and buck/boost switch pattern configuration
// assumes a serial front end delivers completed register writes and reads as strobes
//
// Contract
// R1: after reset the reference is 500 mV, code 0x32, half-step clear.
// R2: reference equals code times 10 mV, plus 5 mV when half-step set.
// R3: span 100 mV at 0x0A to 2550/2555 mV at 0xFF; 0x00-0x09 reserved.
// R4: host should not program codes below 0x0A; disable instead for zero.
// R5: converter off when enable pin low or enable register cleared.
// R6: three gain bits select 87 to 1000 microsiemens per fixed table.
// R7: after reset the gain selection is 101, 500 microsiemens.
// R8: loop level above midpoint: boost, switch1 on, switch2 off, 3/4 alternate.
// R9: loop level below midpoint: buck, switch4 on, switch3 off, 1/2 alternate.
// R10: completed write to code or half-step updates the stored target at once.
`timescale 1ns/1ps
`default_nettype none
`include "rlg_consts.svh"

module rlg_core (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // converter control inputs
    input wire logic enable_pin_i,
    input wire logic loop_above_mid_i,
    input wire logic pwm_phase_i,
    // configuration outputs
    output logic [11:0] ref_mv_o,
    output logic [7:0] ref_code_o,
    output logic ref_code_reserved_o,
    output logic [9:0] gm_us_o,
    output logic [2:0] gain_sel_o,
    output logic [2:0] freq_sel_o,
    output logic conv_en_o,
    output logic boost_mode_o,
    // switch gates
    output logic input_high_switch_o,
    output logic input_low_switch_o,
    output logic output_low_switch_o,
    output logic output_high_switch_o
);

    rlg_pkg::rlg_state_s st_ff;
    rlg_pkg::rlg_state_s nxt_st;

    // gain code to transconductance
    function automatic logic [9:0] gm_decode(input logic [2:0] sel);
        logic [9:0] gm;
        gm = `RLG_GM_0;
        case (sel)
            3'h0: gm = `RLG_GM_0; // R6
            3'h1: gm = `RLG_GM_1;
            3'h2: gm = `RLG_GM_2;
            3'h3: gm = `RLG_GM_3;
            3'h4: gm = `RLG_GM_4;
            3'h5: gm = `RLG_GM_5;
            3'h6: gm = `RLG_GM_6;
            3'h7: gm = `RLG_GM_7;
            default: gm = `RLG_GM_0;
        endcase
        return gm;
    endfunction

    // next state: register writes, reads, decode and switch pattern
    always_comb begin
        logic [7:0] code;
        logic half;
        logic [2:0] gsel;
        logic en_now;
        code = 8'h00;
        half = 1'b0;
        gsel = 3'h0;
        en_now = 1'b0;
        nxt_st = st_ff;
        // register writes land this cycle
        if (reg_wr_i) begin
            case (reg_addr_i)
                `RLG_OFS_ENABLE: begin
                    nxt_st.en_reg = reg_wdata_i[`RLG_EN_BIT]; // R5
                end
                `RLG_OFS_REF_CODE: begin
                    nxt_st.ref_code = reg_wdata_i; // R10
                end
                `RLG_OFS_CONFIG: begin
                    nxt_st.half_step = reg_wdata_i[`RLG_HALF_BIT]; // R10
                    nxt_st.freq_sel = reg_wdata_i[`RLG_FREQ_MSB:0];
                end
                `RLG_OFS_GAIN: begin
                    nxt_st.gain_sel = reg_wdata_i[`RLG_GAIN_MSB:0];
                end
                default: begin
                    nxt_st.en_reg = st_ff.en_reg; // unmapped writes are dropped
                end
            endcase
        end
        code = nxt_st.ref_code;
        half = nxt_st.half_step;
        gsel = nxt_st.gain_sel;
        // register reads answer one cycle later
        nxt_st.rvalid = reg_rd_i;
        nxt_st.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `RLG_OFS_ENABLE: nxt_st.rdata = {7'h00, st_ff.en_reg};
                `RLG_OFS_REF_CODE: nxt_st.rdata = st_ff.ref_code;
                `RLG_OFS_CONFIG: nxt_st.rdata = {3'h0, st_ff.half_step, 1'b0, st_ff.freq_sel};
                `RLG_OFS_GAIN: nxt_st.rdata = {5'h00, st_ff.gain_sel};
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        // reference in millivolts
        nxt_st.ref_mv = 12'({4'h0, code} * `RLG_STEP_MV) + (half ? `RLG_HALF_MV : 12'h000); // R2
        nxt_st.code_reserved = (code < `RLG_CODE_MIN); // R3
        nxt_st.gm_us = gm_decode(gsel); // R6
        // converter enable from pin and register
        en_now = enable_pin_i & nxt_st.en_reg; // R5
        nxt_st.conv_en = en_now;
        // switch pattern from loop level
        if (!en_now) begin
            nxt_st.mode = rlg_pkg::RLG_MODE_OFF;
            nxt_st.sw = 4'h0;
        end else if (loop_above_mid_i) begin
            nxt_st.mode = rlg_pkg::RLG_MODE_BOOST; // R8
            nxt_st.sw = {~pwm_phase_i, pwm_phase_i, 1'b0, 1'b1}; // R8
        end else begin
            nxt_st.mode = rlg_pkg::RLG_MODE_BUCK; // R9
            nxt_st.sw = {1'b1, 1'b0, ~pwm_phase_i, pwm_phase_i}; // R9
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff.en_reg <= `RLG_EN_RST;
            st_ff.ref_code <= `RLG_REF_CODE_RST; // R1
            st_ff.half_step <= `RLG_HALF_RST; // R1
            st_ff.freq_sel <= `RLG_FREQ_RST;
            st_ff.gain_sel <= `RLG_GAIN_RST; // R7
            st_ff.rdata <= 8'h00;
            st_ff.rvalid <= 1'b0;
            st_ff.ref_mv <= `RLG_REF_RST_MV; // R1
            st_ff.gm_us <= `RLG_GM_5; // R7
            st_ff.code_reserved <= 1'b0;
            st_ff.conv_en <= 1'b0;
            st_ff.mode <= rlg_pkg::RLG_MODE_OFF;
            st_ff.sw <= 4'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o = st_ff.rdata;
    assign reg_rvalid_o = st_ff.rvalid;
    assign ref_mv_o = st_ff.ref_mv;
    assign ref_code_o = st_ff.ref_code;
    assign ref_code_reserved_o = st_ff.code_reserved;
    assign gm_us_o = st_ff.gm_us;
    assign gain_sel_o = st_ff.gain_sel;
    assign freq_sel_o = st_ff.freq_sel;
    assign conv_en_o = st_ff.conv_en;
    assign boost_mode_o = st_ff.mode[1]; // boost is the only mode code with bit 1 set
    assign input_high_switch_o = st_ff.sw[0];
    assign input_low_switch_o = st_ff.sw[1];
    assign output_low_switch_o = st_ff.sw[2];
    assign output_high_switch_o = st_ff.sw[3];

    // checks on the design's own behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    AST_REF_SCALE: assert property ( // R2
        ref_mv_o == 12'({4'h0, ref_code_o} * `RLG_STEP_MV)
            + (st_ff.half_step ? `RLG_HALF_MV : 12'h000))
        else $error("reference level does not match code");
    AST_HALF_WRITE: assert property ( // R10
        reg_wr_i && reg_addr_i == `RLG_OFS_CONFIG |=> st_ff.half_step == $past(reg_wdata_i[`RLG_HALF_BIT]))
        else $error("half-step write not stored next cycle");
    AST_REF_WRITE: assert property ( // R10
        reg_wr_i && reg_addr_i == `RLG_OFS_REF_CODE |=> ref_code_o == $past(reg_wdata_i))
        else $error("reference code write not stored next cycle");
    AST_RESERVED: assert property ( // R3
        ref_code_reserved_o == (ref_code_o < `RLG_CODE_MIN))
        else $error("reserved code flag wrong");
    AST_ENABLE: assert property ( // R5
        !enable_pin_i |=> !conv_en_o && !input_high_switch_o && !output_high_switch_o)
        else $error("converter not off with enable pin low");
    AST_EN_REG: assert property ( // R5
        reg_wr_i && reg_addr_i == `RLG_OFS_ENABLE && !reg_wdata_i[`RLG_EN_BIT] |=> !conv_en_o)
        else $error("enable register clear did not stop converter");
    AST_GAIN: assert property ( // R6
        reg_wr_i && reg_addr_i == `RLG_OFS_GAIN && reg_wdata_i[2:0] == 3'h7
            |=> gm_us_o == `RLG_GM_7)
        else $error("gain decode wrong");
    AST_BOOST: assert property ( // R8
        enable_pin_i && st_ff.en_reg && loop_above_mid_i && !reg_wr_i
            |=> boost_mode_o && input_high_switch_o && !input_low_switch_o
                && (output_low_switch_o != output_high_switch_o))
        else $error("boost switch pattern wrong");
    AST_BUCK: assert property ( // R9
        enable_pin_i && st_ff.en_reg && !loop_above_mid_i && !reg_wr_i
            |=> !boost_mode_o && output_high_switch_o && !output_low_switch_o
                && (input_high_switch_o == $past(pwm_phase_i)))
        else $error("buck switch pattern wrong");
    AST_READ: assert property (
        reg_rd_i && reg_addr_i == `RLG_OFS_GAIN |=> reg_rvalid_o && reg_rdata_o[2:0] == $past(st_ff.gain_sel))
        else $error("gain register read wrong");

    COV_BOOST: cover property (conv_en_o && boost_mode_o);
    COV_BUCK_TO_BOOST: cover property (conv_en_o && !boost_mode_o ##1 conv_en_o && boost_mode_o);
    COV_HALF_TOP: cover property (ref_mv_o == 12'h9fb);
    COV_RESERVED: cover property (ref_code_reserved_o);

endmodule // rlg_core

`default_nettype wire

// [testbench/rlg_host_model.sv]
// host side model: hands completed register transfers to the block as strobes
// assumes the block samples its strobes on the rising edge of clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module rlg_host_model (
    // clock
    input wire logic clk_sys_i,
    // register strobes
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    // read answer
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    int gap = 0; // idle cycles before each transfer, for a slow host
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // one transfer; strobes then drop low, address and data lines show the inverse of their last value
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic v);
        repeat (gap) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = wr;
        reg_rd_o = ~wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_sys_i);
        #1;
        q = reg_rdata_i;
        v = reg_rvalid_i;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
endmodule // rlg_host_model
`default_nettype wire

// [testbench/test_reference_and_loop_gain_config.sv]
// self-checking bench of the reference, gain and switch pattern block
// assumes rlg_core, rlg_host_model and rlg_consts.svh are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "rlg_consts.svh"
module test_reference_and_loop_gain_config;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wr, rd, rv, en_pin = 1'b1, above = 1'b0, pwm = 1'b0;
    logic [7:0] addr, wdata, rdata, q;
    logic [11:0] ref_mv;
    logic [7:0] ref_code;
    logic rsv, conv_en, boost, ih, il, ol, oh;
    logic [9:0] gm;
    logic [2:0] gsel, fsel;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [9:0] gm_tab [8] = '{`RLG_GM_0, `RLG_GM_1, `RLG_GM_2, `RLG_GM_3,
        `RLG_GM_4, `RLG_GM_5, `RLG_GM_6, `RLG_GM_7};
    // the host never sends a reserved code
    logic [7:0] codes [4] = '{8'h0a, 8'h32, 8'hc8, 8'hff};
    rlg_host_model u_host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rv));
    rlg_core u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rv), .enable_pin_i(en_pin), .loop_above_mid_i(above),
        .pwm_phase_i(pwm), .ref_mv_o(ref_mv), .ref_code_o(ref_code),
        .ref_code_reserved_o(rsv), .gm_us_o(gm), .gain_sel_o(gsel), .freq_sel_o(fsel),
        .conv_en_o(conv_en), .boost_mode_o(boost), .input_high_switch_o(ih),
        .input_low_switch_o(il), .output_low_switch_o(ol), .output_high_switch_o(oh));
    // clock and cycle ceiling
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic v;
        u_host.xfer(1'b1, a, d, q, v);
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic v;
        u_host.xfer(1'b0, a, 8'h00, q, v);
        chk("rvalid", {11'h0, v}, 12'h1);
        chk("rdata", {4'h0, q}, {4'h0, e});
    endtask
    // reset values on outputs and through reads, unmapped offset included
    task automatic t_reset();
        chk("ref_mv", ref_mv, `RLG_REF_RST_MV);
        chk("ref_code", {4'h0, ref_code}, {4'h0, `RLG_REF_CODE_RST});
        chk("gm", {2'h0, gm}, {2'h0, `RLG_GM_5});
        chk("gain_sel", {9'h0, gsel}, 12'h5);
        rd_chk(`RLG_OFS_REF_CODE, 8'h32);
        rd_chk(`RLG_OFS_CONFIG, 8'h00);
        rd_chk(`RLG_OFS_GAIN, 8'h05);
        rd_chk(8'h05, 8'h00);
        $display("test reset done");
    endtask
    // reference level over the span, both half-step settings
    task automatic t_ref();
        for (int h = 0; h < 2; h++) begin
            wr_reg(`RLG_OFS_CONFIG, h[0] ? 8'h13 : 8'h00);
            chk("freq_sel", {9'h0, fsel}, h[0] ? 12'h003 : 12'h000);
            foreach (codes[i]) begin
                wr_reg(`RLG_OFS_REF_CODE, codes[i]);
                chk("ref_mv", ref_mv,
                    12'(codes[i]) * 12'h00a + (h[0] ? 12'h005 : 12'h000));
                chk("reserved", {11'h0, rsv}, 12'h0);
            end
        end
        u_host.gap = 2;
        rd_chk(`RLG_OFS_REF_CODE, 8'hff);
        u_host.gap = 0;
        rd_chk(`RLG_OFS_CONFIG, 8'h13);
        $display("test reference done");
    endtask
    // every gain encoding
    task automatic t_gain();
        for (int g = 0; g < 8; g++) begin
            wr_reg(`RLG_OFS_GAIN, 8'(g));
            chk("gm", {2'h0, gm}, {2'h0, gm_tab[g]});
        end
        $display("test gain done");
    endtask
    // switch patterns in both modes, then each way of disabling
    task automatic t_sw();
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_sys_i);
            #1;
            above = m[1];
            pwm = m[0];
            en_pin = (m != 4);
            if (m == 5) wr_reg(`RLG_OFS_ENABLE, 8'h00);
            repeat (2) @(posedge clk_sys_i);
            #1;
            if (m >= 4) chk("sw_off", {7'h0, conv_en, ih, il, ol, oh}, 12'h0);
            else if (above) chk("boost", {7'h0, boost, ih, il, ol, oh},
                {7'h0, 3'b110, pwm, ~pwm});
            else chk("buck", {7'h0, boost, ih, il, ol, oh}, {7'h0, 1'b0, pwm, ~pwm, 2'b01});
            if (m == 4) en_pin = 1'b1;
        end
        wr_reg(`RLG_OFS_ENABLE, 8'h01);
        chk("conv_en", {11'h0, conv_en}, 12'h1);
        $display("test switch done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1;
        arst_n_i = 1'b1;
        t_reset();
        t_ref();
        t_gain();
        t_sw();
        wrap_up();
    end
endmodule // test_reference_and_loop_gain_config
`default_nettype wire
